// >>> src/eps_map.svh
// constants for the egress priority scheduler
// assumes inclusion by the package and the design files
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH
`define EPS_DATA_W      8
`define EPS_Q_DEPTH     16
`define EPS_Q_AW        4
`define EPS_CNT_W       5
`define EPS_RATIO_4     5'h04
`define EPS_RATIO_8     5'h08
`define EPS_RATIO_16    5'h10
`define EPS_POL_4TO1    2'h0
`define EPS_POL_8TO1    2'h1
`define EPS_POL_16TO1   2'h2
`define EPS_POL_STRICT  2'h3
`define EPS_POL_RESET   2'h0
`endif

// >>> src/eps_pkg.sv
// types for the egress priority scheduler
// assumes eps_map.svh is on the include path
`include "eps_map.svh"
package eps_pkg;
   typedef enum logic [1:0] {
      POL_4TO1,
      POL_8TO1,
      POL_16TO1,
      POL_STRICT
   } eps_pol_t;
   typedef enum {
      ST_IDLE,
      ST_SEND
   } eps_state_t;
endpackage

// >>> src/eps_queue.sv
// packet queue: a byte fifo with a last-byte flag per entry
// assumes one clock, async active-low reset
`timescale 1ns/100ps
`include "eps_map.svh"
module eps_queue
   import eps_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // fill side
   input  wire logic                   in_valid,
   input  wire logic [`EPS_DATA_W-1:0] in_data,
   input  wire logic                   in_last,
   output logic                        in_ready,
   // drain side
   output logic                        out_valid,
   output logic [`EPS_DATA_W-1:0]      out_data,
   output logic                        out_last,
   input  wire logic                   out_ready,
   // whole packets held
   output logic                        has_pkt
);
   logic [`EPS_DATA_W:0]   mem [0:`EPS_Q_DEPTH-1];
   logic [`EPS_Q_AW:0]     wp_q;
   logic [`EPS_Q_AW:0]     rp_q;
   logic [`EPS_Q_AW:0]     pk_q;
   logic                   push;
   logic                   pop;
   logic                   pk_in;
   logic                   pk_out;

   assign in_ready  = (wp_q - rp_q) != (`EPS_Q_AW+1)'(`EPS_Q_DEPTH);
   assign out_valid = wp_q != rp_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rp_q[`EPS_Q_AW-1:0]][`EPS_DATA_W-1:0];
   assign out_last  = mem[rp_q[`EPS_Q_AW-1:0]][`EPS_DATA_W];
   assign pk_in     = push & in_last;
   assign pk_out    = pop & out_last;
   assign has_pkt   = pk_q != '0;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q[`EPS_Q_AW-1:0]] <= {in_last, in_data};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         pk_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         // full packets only, so the scheduler never starts a partial one
         if (pk_in & ~pk_out) pk_q <= pk_q + 1'b1;
         else if (pk_out & ~pk_in) pk_q <= pk_q - 1'b1;
      end
   end
endmodule

// >>> src/eps_sched.sv
// egress priority scheduler: two queues and a service policy
// assumes the fabric classifies packets and the mac drains one byte per accepted cycle
`timescale 1ns/100ps
`include "eps_map.svh"
// Function
// - Each egress port keeps two transmit queues, high and low.
// - High-marked packets go to the high queue, low-marked to the low.
// - Service order follows one of four configured policies.
// - Ratio mode: N high packets then one low, N is 4, 8 or 16.
// - Strict mode: serve high whenever it holds a packet, low only otherwise.
// - Packet is high if any enabled classifier says high, else low.
module eps_sched
   import eps_pkg::*;
(
   // clock and reset
   input  wire logic                   REF_CLK,
   input  wire logic                   RSTN,
   // configuration
   input  wire logic [1:0]             POLICY,
   input  wire logic [3:0]             CLASS_EN,
   // fabric side
   input  wire logic                   IN_VALID,
   input  wire logic [`EPS_DATA_W-1:0] IN_DATA,
   input  wire logic                   IN_LAST,
   input  wire logic [3:0]             IN_CLASS_HI,
   output logic                        IN_READY,
   // mac side
   output logic                        TX_VALID,
   output logic [`EPS_DATA_W-1:0]      TX_DATA,
   output logic                        TX_LAST,
   output logic                        TX_FROM_HI,
   input  wire logic                   TX_READY
);
   // ----------------------------------------
   // classification and queues
   // ----------------------------------------
   logic             pri_q;
   logic             mid_pkt_q;
   logic             pri_now;
   logic [1:0]       in_v;
   logic [1:0]       in_r;
   logic [1:0]       q_v;
   logic [1:0]       q_l;
   logic [1:0]       q_r;
   logic [1:0]       q_pk;
   logic [`EPS_DATA_W-1:0] q_d [0:1];

   assign pri_now = mid_pkt_q ? pri_q : |(CLASS_EN & IN_CLASS_HI);

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pri_q     <= 1'b0;
         mid_pkt_q <= 1'b0;
      end else if (IN_VALID && IN_READY) begin
         pri_q     <= pri_now;
         mid_pkt_q <= ~IN_LAST;
      end
   end

   assign in_v[1]  = IN_VALID & pri_now;
   assign in_v[0]  = IN_VALID & ~pri_now;
   assign IN_READY = pri_now ? in_r[1] : in_r[0];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_q
         eps_queue u_q (
            .clk       (REF_CLK),
            .rst_n     (RSTN),
            .in_valid  (in_v[gi]),
            .in_data   (IN_DATA),
            .in_last   (IN_LAST),
            .in_ready  (in_r[gi]),
            .out_valid (q_v[gi]),
            .out_data  (q_d[gi]),
            .out_last  (q_l[gi]),
            .out_ready (q_r[gi]),
            .has_pkt   (q_pk[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // service policy
   // ----------------------------------------
   function automatic logic [`EPS_CNT_W-1:0] ratio_of(input logic [1:0] p);
      case (p)
         `EPS_POL_4TO1:  ratio_of = `EPS_RATIO_4;
         `EPS_POL_8TO1:  ratio_of = `EPS_RATIO_8;
         `EPS_POL_16TO1: ratio_of = `EPS_RATIO_16;
         default:        ratio_of = `EPS_RATIO_4;
      endcase
   endfunction

   eps_state_t             st_q;
   logic                   sel_q;
   logic                   pick_hi;
   logic [`EPS_CNT_W-1:0]  cnt_q;
   logic                   take;
   logic                   done;

   // fall back when due queue empty
   always_comb begin
      if (POLICY == `EPS_POL_STRICT) pick_hi = q_pk[1];
      else if (cnt_q >= ratio_of(POLICY)) pick_hi = ~q_pk[0];
      else pick_hi = q_pk[1];
   end

   // output register stage: drain holds while the mac stalls
   assign take = (st_q == ST_SEND) && (!TX_VALID || TX_READY) && q_v[sel_q];
   assign q_r[1] = take & sel_q;
   assign q_r[0] = take & ~sel_q;
   assign done = take & q_l[sel_q];

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q  <= ST_IDLE;
         sel_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (q_pk != 2'b00) begin
                  st_q  <= ST_SEND;
                  sel_q <= pick_hi;
               end
            end
            ST_SEND: begin
               if (done) st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_q <= '0;
      end else if (done) begin
         if (!sel_q) cnt_q <= '0;
         else if (cnt_q != `EPS_RATIO_16) cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         TX_VALID   <= 1'b0;
         TX_DATA    <= '0;
         TX_LAST    <= 1'b0;
         TX_FROM_HI <= 1'b0;
      end else if (take) begin
         TX_VALID   <= 1'b1;
         TX_DATA    <= q_d[sel_q];
         TX_LAST    <= q_l[sel_q];
         TX_FROM_HI <= sel_q;
      end else if (TX_READY) begin
         TX_VALID   <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_strict_hi;
      @(posedge REF_CLK) disable iff (!RSTN)
      (st_q == ST_IDLE && q_pk[1] && POLICY == `EPS_POL_STRICT) |=> sel_q;
   endproperty
   a_strict_hi: assert property (p_strict_hi) else $error("strict picked low with high waiting");

   property p_ratio_low;
      @(posedge REF_CLK) disable iff (!RSTN)
      (st_q == ST_IDLE && q_pk[0] && POLICY != `EPS_POL_STRICT && cnt_q >= ratio_of(POLICY)) |=> !sel_q;
   endproperty
   a_ratio_low: assert property (p_ratio_low) else $error("low not served when due");

   property p_work_cons;
      @(posedge REF_CLK) disable iff (!RSTN)
      (st_q == ST_IDLE && q_pk == 2'b01) |=> (st_q == ST_SEND && !sel_q);
   endproperty
   a_work_cons: assert property (p_work_cons) else $error("idle with only low waiting");

   property p_cnt_clr;
      @(posedge REF_CLK) disable iff (!RSTN)
      (done && !sel_q) |=> cnt_q == '0;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("count kept after low packet");

   property p_steer;
      @(posedge REF_CLK) disable iff (!RSTN)
      (IN_VALID && !mid_pkt_q && |(CLASS_EN & IN_CLASS_HI)) |-> (in_v == 2'b10);
   endproperty
   a_steer: assert property (p_steer) else $error("high packet not steered high");

   property p_class;
      @(posedge REF_CLK) disable iff (!RSTN)
      (IN_VALID && !mid_pkt_q && (CLASS_EN & IN_CLASS_HI) == 4'h0) |-> (in_v == 2'b01);
   endproperty
   a_class: assert property (p_class) else $error("unclassified packet not low");

   property p_src;
      @(posedge REF_CLK) disable iff (!RSTN)
      take |=> (TX_VALID && TX_FROM_HI == $past(sel_q));
   endproperty
   a_src: assert property (p_src) else $error("output source mismatch");

   property p_hold;
      @(posedge REF_CLK) disable iff (!RSTN)
      (TX_VALID && !TX_READY) |=> (TX_VALID && $stable(TX_DATA));
   endproperty
   a_hold: assert property (p_hold) else $error("tx data dropped under stall");
endmodule

// >>> verification/eps_mac_model.sv
// mac-side partner: accepts bytes and logs each packet
// assumes the scheduler's registered tx outputs and one clock
`timescale 1ns/100ps
`include "eps_map.svh"
module eps_mac_model (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // mac side
   input  wire logic                   tx_valid,
   input  wire logic [`EPS_DATA_W-1:0] tx_data,
   input  wire logic                   tx_last,
   input  wire logic                   tx_from_hi,
   output logic                        tx_ready,
   // pacing from the bench
   input  wire logic                   hold,
   input  wire logic                   slow
);
   // ------------------------------
   // packet log
   // ------------------------------
   logic [`EPS_DATA_W-1:0] pkt_data [0:63];
   logic                   pkt_hi   [0:63];
   int                     pkt_len  [0:63];
   int                     n_pkt;
   int                     cur_len;

   // slow mode toggles ready so the held outputs are exercised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         n_pkt    <= 0;
         cur_len  <= 0;
      end else begin
         tx_ready <= !hold && (!slow || !tx_ready);
         if (tx_valid && tx_ready) begin
            if (cur_len == 0) begin
               pkt_data[n_pkt] <= tx_data;
               pkt_hi[n_pkt]   <= tx_from_hi;
            end
            cur_len <= tx_last ? 0 : cur_len + 1;
            if (tx_last) begin
               pkt_len[n_pkt] <= cur_len + 1;
               n_pkt          <= n_pkt + 1;
            end
         end
      end
   end
endmodule

// >>> verification/tb_eps_sched.sv
// bench for the egress scheduler: loads queues while the mac stalls
// assumes eps_mac_model as the mac and the bench as the fabric
`timescale 1ns/100ps
module tb_eps_sched;
   logic       ref_clk = 1'b0, rstn = 1'b0, in_valid = 1'b0, in_last = 1'b0, hold = 1'b1, slow = 1'b0;
   logic [1:0] policy = 2'h0;
   logic [3:0] in_class_hi = 4'h0, class_en = 4'h6;
   logic [7:0] in_data = 8'h00, tx_data;
   logic       in_ready, tx_valid, tx_last, tx_from_hi, tx_ready;
   int         num_errors = 0, n_compared = 0;

   always #5 ref_clk = ~ref_clk;

   eps_sched u_eps_sched (.REF_CLK(ref_clk), .RSTN(rstn), .POLICY(policy), .CLASS_EN(class_en),
      .IN_VALID(in_valid), .IN_DATA(in_data), .IN_LAST(in_last), .IN_CLASS_HI(in_class_hi),
      .IN_READY(in_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
      .TX_FROM_HI(tx_from_hi), .TX_READY(tx_ready));
   eps_mac_model u_eps_mac_model (.clk(ref_clk), .rst_n(rstn), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_from_hi(tx_from_hi), .tx_ready(tx_ready), .hold(hold), .slow(slow));

   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic complete_run;
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // 4'h9 only sets disabled verdicts, so it must land low
   // later bytes carry the opposite verdict: only the first byte may steer
   task automatic send_pkt(input logic hi, input logic [7:0] tag, input int len);
      logic taken;
      for (int b = 0; b < len; b++) begin
         in_valid    = 1'b1;
         in_data     = tag + b[7:0];
         in_last     = (b == len - 1);
         in_class_hi = (hi ^ (b != 0)) ? 4'h4 : 4'h9;
         taken       = 1'b0;
         for (int k = 0; k < 200 && !taken; k++) begin
            @(negedge ref_clk);
            taken = (in_ready === 1'b1);
            @(posedge ref_clk);
            #1;
         end
         if (!taken) begin
            num_errors++;
            complete_run();
         end
      end
      in_valid = 1'b0;
      // one idle edge so a following call never re-raises valid in the same step
      @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_pkts(input int target);
      for (int k = 0; k < 3000 && u_eps_mac_model.n_pkt < target; k++)
         @(posedge ref_clk);
      #1;
      if (u_eps_mac_model.n_pkt < target) begin
         num_errors++;
         complete_run();
      end
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   // n+1 high then two low: a wrong n reorders the output
   task automatic test_ratio(input logic [1:0] pol, input int n);
      int base;
      base   = u_eps_mac_model.n_pkt;
      hold   = 1'b1;
      policy = pol;
      for (int k = 0; k <= n; k++)
         send_pkt(1'b1, k[7:0], 1);
      check("high queue ready", in_ready, n < 16);
      send_pkt(1'b0, 8'h80, 1);
      send_pkt(1'b0, 8'h81, 1);
      hold = 1'b0;
      wait_pkts(base + n + 3);
      for (int k = 0; k < n + 3; k++) begin
         check("ratio queue", u_eps_mac_model.pkt_hi[base+k], (k != n && k != n + 2));
         check("ratio data", u_eps_mac_model.pkt_data[base+k],
               k < n ? k : k == n ? 8'h80 : k == n + 1 ? n : 8'h81);
      end
   endtask

   // six two-byte high packets must all precede the low ones
   task automatic test_strict;
      int base;
      base   = u_eps_mac_model.n_pkt;
      hold   = 1'b1;
      slow   = 1'b1;
      policy = 2'h3;
      // other enable mask: 4'h9 still carries no enabled high verdict
      class_en = 4'h4;
      for (int k = 0; k < 6; k++)
         send_pkt(1'b1, 8'(2 * k), 2);
      send_pkt(1'b0, 8'h80, 2);
      send_pkt(1'b0, 8'h82, 2);
      hold = 1'b0;
      wait_pkts(base + 8);
      for (int k = 0; k < 8; k++) begin
         check("strict queue", u_eps_mac_model.pkt_hi[base+k], k < 6);
         check("strict data", u_eps_mac_model.pkt_data[base+k], k < 6 ? 2 * k : 8'h80 + 2 * (k - 6));
         check("strict length", u_eps_mac_model.pkt_len[base+k], 2);
      end
      slow = 1'b0;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      check("idle valid", tx_valid, 1'b0);
      check("idle ready", in_ready, 1'b1);
      test_ratio(2'h0, 4);
      test_ratio(2'h1, 8);
      test_ratio(2'h2, 16);
      test_strict();
      complete_run();
   end
endmodule
